// [pkg/fpfmt_pkg.sv]
package fpfmt_pkg;
   // Word and field geometry
   localparam int WORD_W = 24;
   localparam int FIX_SIGN = 23;
   localparam int FP_W = 48;
   localparam int FP_SIGN = 47;
   localparam int EXP_MSB = 46;
   localparam int EXP_LSB = 36;
   localparam int EXP_W = 11;
   localparam int COEF_W = 36;
   localparam int COEF_MSB = 35;
   localparam int TEXP_W = 10;
   localparam int EXT_W = 48;
   localparam int CHAIN_W = 85;
   localparam int ADDR_W = 18;
   localparam int CNT_W = 6;
   // Exponent bias values
   localparam logic [EXP_W-1:0] BIAS_POS = 11'h400;
   localparam logic [EXP_W-1:0] BIAS_NEG = 11'h3FF;
   // Alignment limits, address step and count constants
   localparam logic [CNT_W-1:0] MAX_SHIFT = 6'h3F;
   localparam logic [EXP_W-1:0] MAX_SHIFT_X = 11'h03F;
   localparam logic [EXP_W-1:0] LARGER_LIMIT = 11'h024;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h0_0001;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [TEXP_W-1:0] TEXP_ZERO = 10'h000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_IND,
      ST_RD_HI,
      ST_RD_LO,
      ST_SETUP,
      ST_SHIFT,
      ST_DONE
   } seq_e;
endpackage : fpfmt_pkg

// [rtl/exp_bias_encode.sv]
`timescale 1ns/10ps
module exp_bias_encode (
   // True exponent, sign and magnitude
   input  wire logic                           neg_i,
   input  wire logic [fpfmt_pkg::TEXP_W-1:0]   mag_i,
   // Biased exponent
   output logic      [fpfmt_pkg::EXP_W-1:0]    bexp_o
);
   logic [fpfmt_pkg::EXP_W-1:0] mag_x;

   assign mag_x = {1'b0, mag_i};

   always_comb begin
      if (neg_i && (mag_i != fpfmt_pkg::TEXP_ZERO)) begin
         bexp_o = fpfmt_pkg::BIAS_NEG - mag_x;
      end else begin
         bexp_o = fpfmt_pkg::BIAS_POS + mag_x;
      end
   end
endmodule : exp_bias_encode

// [rtl/ones_comp_compare.sv]
`timescale 1ns/10ps
module ones_comp_compare (
   // Operands, one's complement
   input  wire logic [fpfmt_pkg::FP_W-1:0] a_i,
   input  wire logic [fpfmt_pkg::FP_W-1:0] b_i,
   // Result
   output logic                            gt_o,
   output logic                            eq_o
);
   logic [fpfmt_pkg::FP_W-1:0] a_z;
   logic [fpfmt_pkg::FP_W-1:0] b_z;

   assign a_z = (&a_i) ? '0 : a_i;
   assign b_z = (&b_i) ? '0 : b_i;

   // plain signed compare
   // One's complement order matches two's complement once minus zero folds
   assign gt_o = $signed(a_z) > $signed(b_z);
   assign eq_o = (a_z == b_z);
endmodule : ones_comp_compare

// [rtl/float_operand_format_align.sv]
`timescale 1ns/10ps
module float_operand_format_align (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              srst_i,
   // Fixed-point operand decode
   input  wire logic [fpfmt_pkg::WORD_W-1:0]      fix_word_i,
   output logic                                   fix_sign_o,
   output logic      [fpfmt_pkg::FIX_SIGN-1:0]    fix_mag_o,
   output logic      [fpfmt_pkg::WORD_W-1:0]      fix_value_o,
   // Trap decision
   input  wire logic                              mul48_i,
   input  wire logic                              div48_i,
   input  wire logic                              arith_opt_i,
   output logic                                   trap_o,
   // Exponent encode
   input  wire logic                              texp_neg_i,
   input  wire logic [fpfmt_pkg::TEXP_W-1:0]      texp_mag_i,
   output logic      [fpfmt_pkg::EXP_W-1:0]       bexp_o,
   // Combined accumulator pair and its decode
   input  wire logic [fpfmt_pkg::FP_W-1:0]        aq_i,
   output logic                                   fp_sign_o,
   output logic      [fpfmt_pkg::EXP_W-1:0]       fp_bexp_o,
   output logic      [fpfmt_pkg::COEF_W-1:0]      fp_coef_o,
   output logic                                   fp_norm_o,
   output logic                                   fp_texp_neg_o,
   output logic      [fpfmt_pkg::TEXP_W-1:0]      fp_texp_mag_o,
   // Compare against pair
   input  wire logic [fpfmt_pkg::FP_W-1:0]        cmp_b_i,
   output logic                                   cmp_gt_o,
   output logic                                   cmp_eq_o,
   // Equalize request
   input  wire logic                              fp_start_i,
   input  wire logic                              fp_sub_i,
   input  wire logic [fpfmt_pkg::ADDR_W-1:0]      exec_addr_i,
   input  wire logic [fpfmt_pkg::ADDR_W-1:0]      index_i,
   input  wire logic                              index_en_i,
   input  wire logic                              indirect_i,
   // Storage read port
   output logic                                   mem_rd_o,
   output logic      [fpfmt_pkg::ADDR_W-1:0]      mem_addr_o,
   input  wire logic                              mem_ack_i,
   input  wire logic [fpfmt_pkg::WORD_W-1:0]      mem_rdata_i,
   // Equalize result
   output logic                                   busy_o,
   output logic                                   done_o,
   output logic      [fpfmt_pkg::FP_W-1:0]        opnd_o,
   output logic      [fpfmt_pkg::EXP_W-1:0]       eq_exp_o,
   output logic      [fpfmt_pkg::COEF_W:0]        aligned_coef_o,
   output logic      [fpfmt_pkg::EXT_W-1:0]       aligned_ext_o,
   output logic      [fpfmt_pkg::COEF_W:0]        other_coef_o,
   output logic                                   shifted_aq_o,
   output logic                                   larger_only_o,
   output logic      [fpfmt_pkg::CNT_W-1:0]       shift_cnt_o
);
   localparam int W = fpfmt_pkg::WORD_W;
   localparam int AW = fpfmt_pkg::ADDR_W;
   localparam int EW = fpfmt_pkg::EXP_W;
   localparam int CW = fpfmt_pkg::COEF_W;
   localparam int XW = fpfmt_pkg::EXT_W;
   localparam int HW = fpfmt_pkg::CHAIN_W;

   fpfmt_pkg::seq_e state_r;
   fpfmt_pkg::seq_e state_nxt;

   logic [AW-1:0] addr_r;
   logic [W-1:0] hi_r;
   logic [W-1:0] lo_r;
   logic [fpfmt_pkg::FP_W-1:0] aq_r;
   logic sub_r;
   logic [HW-1:0] chain_r;
   logic [HW-1:0] chain_nxt;
   logic [CW:0] other_r;
   logic [EW-1:0] eq_exp_r;
   logic [fpfmt_pkg::CNT_W-1:0] cnt_r;
   logic [fpfmt_pkg::CNT_W-1:0] target_r;
   logic shifted_aq_r;
   logic larger_only_r;

   logic [fpfmt_pkg::FP_W-1:0] opnd_w;
   logic [EW-1:0] exp_aq;
   logic [EW-1:0] exp_m;
   logic [CW:0] coef_aq;
   logic [CW:0] coef_m;
   logic aq_smaller;
   logic [EW-1:0] diff;
   logic [HW-1:0] init_chain;
   logic [HW-1:0] step_chain;
   logic last_step;
   logic [EW-1:0] bexp_w;
   logic cmp_gt_w;
   logic cmp_eq_w;

   // One's complement add with end-around carry
   function automatic logic [AW-1:0] oc_add(
      input logic [AW-1:0] a,
      input logic [AW-1:0] b
   );
      logic [AW:0] s;
      s = {1'b0, a} + {1'b0, b};
      oc_add = s[AW-1:0] + {{(AW-1){1'b0}}, s[AW]};
   endfunction : oc_add

   // True biased exponent of a float word
   function automatic logic [EW-1:0] exp_of(
      input logic [fpfmt_pkg::FP_W-1:0] w
   );
      logic [EW-1:0] e;
      e = w[fpfmt_pkg::EXP_MSB:fpfmt_pkg::EXP_LSB];
      exp_of = w[fpfmt_pkg::FP_SIGN] ? ~e : e;
   endfunction : exp_of

   // Fixed-point decode
   // sign and coefficient split
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fix_sign_o <= 1'b0;
         fix_mag_o  <= '0;
      end else begin
         fix_sign_o <= fix_word_i[fpfmt_pkg::FIX_SIGN];
         fix_mag_o  <= fix_word_i[fpfmt_pkg::FIX_SIGN] ?
                       ~fix_word_i[fpfmt_pkg::FIX_SIGN-1:0] :
                       fix_word_i[fpfmt_pkg::FIX_SIGN-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fix_value_o <= '0;
      end else begin
         fix_value_o <= (&fix_word_i) ? '0 : fix_word_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         trap_o <= 1'b0;
      end else begin
         trap_o <= (mul48_i || div48_i) && !arith_opt_i;
      end
   end

   exp_bias_encode u_enc (
      .neg_i  (texp_neg_i),
      .mag_i  (texp_mag_i),
      .bexp_o (bexp_w)
   );

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bexp_o <= '0;
      end else begin
         bexp_o <= bexp_w;
      end
   end

   // Float decode of the pair
   // pair read as one word
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fp_sign_o <= 1'b0;
         fp_bexp_o <= '0;
         fp_coef_o <= '0;
      end else begin
         fp_sign_o <= aq_i[fpfmt_pkg::FP_SIGN];
         fp_bexp_o <= exp_of(aq_i);
         fp_coef_o <= aq_i[fpfmt_pkg::FP_SIGN] ?
                      ~aq_i[CW-1:0] : aq_i[CW-1:0];
      end
   end

   // normalized when top fraction bit set
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fp_norm_o <= 1'b0;
      end else begin
         fp_norm_o <= aq_i[fpfmt_pkg::COEF_MSB] ^
                      aq_i[fpfmt_pkg::FP_SIGN];
      end
   end

   // biased field back to true value
   // field 2000 reads as plus zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fp_texp_neg_o <= 1'b0;
         fp_texp_mag_o <= '0;
      end else if (exp_of(aq_i) >= fpfmt_pkg::BIAS_POS) begin
         fp_texp_neg_o <= 1'b0;
         fp_texp_mag_o <=
            fpfmt_pkg::TEXP_W'(exp_of(aq_i) - fpfmt_pkg::BIAS_POS);
      end else begin
         fp_texp_neg_o <= 1'b1;
         fp_texp_mag_o <=
            fpfmt_pkg::TEXP_W'(fpfmt_pkg::BIAS_NEG - exp_of(aq_i));
      end
   end

   ones_comp_compare u_cmp (
      .a_i  (aq_i),
      .b_i  (cmp_b_i),
      .gt_o (cmp_gt_w),
      .eq_o (cmp_eq_w)
   );

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cmp_gt_o <= 1'b0;
         cmp_eq_o <= 1'b0;
      end else begin
         cmp_gt_o <= cmp_gt_w;
         cmp_eq_o <= cmp_eq_w;
      end
   end

   // Operand fetch and alignment sequencer
   assign opnd_w = {hi_r, lo_r};
   assign exp_aq = exp_of(aq_r);
   assign exp_m = exp_of(opnd_w);
   assign coef_aq = {aq_r[fpfmt_pkg::FP_SIGN], aq_r[CW-1:0]};
   assign coef_m = sub_r ?
                   ~{opnd_w[fpfmt_pkg::FP_SIGN], opnd_w[CW-1:0]} :
                   {opnd_w[fpfmt_pkg::FP_SIGN], opnd_w[CW-1:0]};
   assign aq_smaller = exp_aq < exp_m;
   assign diff = aq_smaller ? (exp_m - exp_aq) : (exp_aq - exp_m);
   // Extension starts as sign fill, so the chain stays one's complement
   assign init_chain = aq_smaller ? {coef_aq, {XW{coef_aq[CW]}}} :
                                    {coef_m, {XW{coef_m[CW]}}};
   assign step_chain = {chain_r[HW-1], chain_r[HW-1:1]};
   assign last_step = (state_r == fpfmt_pkg::ST_SHIFT) &&
                      ((cnt_r + fpfmt_pkg::CNT_ONE) == target_r);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fpfmt_pkg::ST_IDLE: begin
            if (fp_start_i) begin
               state_nxt = indirect_i ? fpfmt_pkg::ST_IND :
                                        fpfmt_pkg::ST_RD_HI;
            end
         end
         fpfmt_pkg::ST_IND: begin
            if (mem_ack_i) begin
               state_nxt = fpfmt_pkg::ST_RD_HI;
            end
         end
         fpfmt_pkg::ST_RD_HI: begin
            if (mem_ack_i) begin
               state_nxt = fpfmt_pkg::ST_RD_LO;
            end
         end
         fpfmt_pkg::ST_RD_LO: begin
            if (mem_ack_i) begin
               state_nxt = fpfmt_pkg::ST_SETUP;
            end
         end
         fpfmt_pkg::ST_SETUP: begin
            state_nxt = (diff == '0) ? fpfmt_pkg::ST_DONE :
                                       fpfmt_pkg::ST_SHIFT;
         end
         fpfmt_pkg::ST_SHIFT: begin
            if (last_step) begin
               state_nxt = fpfmt_pkg::ST_DONE;
            end
         end
         fpfmt_pkg::ST_DONE: begin
            state_nxt = fpfmt_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= fpfmt_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         addr_r <= '0;
      end else if (state_r == fpfmt_pkg::ST_IDLE && fp_start_i) begin
         addr_r <= index_en_i ? oc_add(exec_addr_i, index_i) :
                                exec_addr_i;
      end else if (state_r == fpfmt_pkg::ST_IND && mem_ack_i) begin
         addr_r <= mem_rdata_i[AW-1:0];
      end else if (state_r == fpfmt_pkg::ST_RD_HI && mem_ack_i) begin
         addr_r <= addr_r + fpfmt_pkg::ADDR_STEP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hi_r <= '0;
         lo_r <= '0;
      end else if (mem_ack_i) begin
         if (state_r == fpfmt_pkg::ST_RD_HI) begin
            hi_r <= mem_rdata_i;
         end
         if (state_r == fpfmt_pkg::ST_RD_LO) begin
            lo_r <= mem_rdata_i;
         end
      end
   end

   // Pair is sampled at start; caller may change it mid-sequence
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aq_r  <= '0;
         sub_r <= 1'b0;
      end else if (state_r == fpfmt_pkg::ST_IDLE && fp_start_i) begin
         aq_r  <= aq_i;
         sub_r <= fp_sub_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         target_r      <= fpfmt_pkg::CNT_ZERO;
         larger_only_r <= 1'b0;
         shifted_aq_r  <= 1'b0;
         eq_exp_r      <= '0;
         other_r       <= '0;
      end else if (state_r == fpfmt_pkg::ST_SETUP) begin
         target_r      <= (diff > fpfmt_pkg::MAX_SHIFT_X) ?
                          fpfmt_pkg::MAX_SHIFT :
                          diff[fpfmt_pkg::CNT_W-1:0];
         larger_only_r <= diff > fpfmt_pkg::LARGER_LIMIT;
         shifted_aq_r  <= aq_smaller;
         eq_exp_r      <= aq_smaller ? exp_m : exp_aq;
         other_r       <= aq_smaller ? coef_m : coef_aq;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_r <= fpfmt_pkg::CNT_ZERO;
      end else if (state_r == fpfmt_pkg::ST_SETUP) begin
         cnt_r <= fpfmt_pkg::CNT_ZERO;
      end else if (state_r == fpfmt_pkg::ST_SHIFT) begin
         cnt_r <= cnt_r + fpfmt_pkg::CNT_ONE;
      end
   end

   always_comb begin
      chain_nxt = chain_r;
      if (state_r == fpfmt_pkg::ST_SETUP) begin
         chain_nxt = init_chain;
      end else if (state_r == fpfmt_pkg::ST_SHIFT) begin
         chain_nxt = step_chain;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         chain_r <= '0;
      end else if ((state_r == fpfmt_pkg::ST_SETUP && diff == '0) ||
                   last_step) begin
         chain_r <= (&chain_nxt) ? '0 : chain_nxt;
      end else begin
         chain_r <= chain_nxt;
      end
   end

   // Outputs
   assign mem_rd_o = (state_r == fpfmt_pkg::ST_IND) ||
                     (state_r == fpfmt_pkg::ST_RD_HI) ||
                     (state_r == fpfmt_pkg::ST_RD_LO);
   assign mem_addr_o = addr_r;
   assign busy_o = (state_r != fpfmt_pkg::ST_IDLE);
   assign done_o = (state_r == fpfmt_pkg::ST_DONE);
   assign opnd_o = opnd_w;
   assign eq_exp_o = eq_exp_r;
   assign aligned_coef_o = chain_r[HW-1:XW];
   assign aligned_ext_o = chain_r[XW-1:0];
   assign other_coef_o = other_r;
   assign shifted_aq_o = shifted_aq_r;
   assign larger_only_o = larger_only_r;
   assign shift_cnt_o = cnt_r;
endmodule : float_operand_format_align

// [verif/fp_store_model.sv]
`timescale 1ns/10ps
module fp_store_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Extra wait cycles before each answer
   input  wire logic [1:0]  lat_i,
   // Storage read port
   input  wire logic        mem_rd_i,
   input  wire logic [17:0] mem_addr_i,
   output logic             mem_ack_o,
   output logic      [23:0] mem_rdata_o
);
   logic [23:0] mem [256];
   logic [1:0]  wait_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wait_r      <= 2'h0;
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 24'h00_0000;
      end else if (mem_rd_i && !mem_ack_o && wait_r == lat_i) begin
         wait_r      <= 2'h0;
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= mem[mem_addr_i[7:0]];
      end else begin
         // Data flips when not acked, so a late capture shows
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         if (mem_rd_i && !mem_ack_o) begin
            wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule : fp_store_model

// [verif/float_operand_format_align_props.sv]
`timescale 1ns/10ps
module fpfa_checker (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        srst_i,
   // Decode paths
   input wire logic        mul48_i,
   input wire logic        div48_i,
   input wire logic        arith_opt_i,
   input wire logic        trap_o,
   input wire logic        texp_neg_i,
   input wire logic [9:0]  texp_mag_i,
   input wire logic [10:0] bexp_o,
   input wire logic [47:0] aq_i,
   input wire logic        fp_sign_o,
   input wire logic [10:0] fp_bexp_o,
   input wire logic [35:0] fp_coef_o,
   // Sequencer
   input wire logic        fp_start_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic        mem_rd_o,
   input wire logic [17:0] mem_addr_o,
   input wire logic        mem_ack_i,
   input wire logic [36:0] aligned_coef_o,
   input wire logic [47:0] aligned_ext_o,
   input wire logic        larger_only_o,
   input wire logic [5:0]  shift_cnt_o
);
   logic [47:0] aq_q;

   default clocking dck @(posedge clk_i); endclocking
   default disable iff (srst_i);

   always_ff @(posedge clk_i) begin
      aq_q <= aq_i;
   end

   sequence start_seq;
      fp_start_i && !busy_o;
   endsequence

   sequence fetch_seq;
      busy_o && mem_rd_o;
   endsequence

   trap_gate_a : assert property (
      !$past(srst_i) |-> trap_o ==
      (($past(mul48_i) || $past(div48_i)) && !$past(arith_opt_i)))
      else $error("trap output wrong");
   exp_bias_a : assert property (
      !$past(srst_i) |-> bexp_o ==
      (($past(texp_neg_i) && $past(texp_mag_i) != 10'h000) ?
      11'h3FF - {1'b0, $past(texp_mag_i)} : 11'h400 + {1'b0, $past(texp_mag_i)}))
      else $error("biased exponent wrong");
   pair_fields_a : assert property (
      !$past(srst_i) |-> fp_sign_o == aq_q[47] &&
      {fp_bexp_o, fp_coef_o} == (aq_q[47] ? ~aq_q[46:0] : aq_q[46:0]))
      else $error("pair fields wrong");
   start_fetch_a : assert property (
      start_seq |=> fetch_seq)
      else $error("start did not fetch");
   start_done_a : assert property (
      start_seq |-> ##[4:400] done_o)
      else $error("no done after start");
   read_hold_a : assert property (
      mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
      else $error("read dropped before ack");
   done_pulse_a : assert property (
      done_o |=> !done_o && !busy_o)
      else $error("done not one cycle");
   shift_cap_a : assert property (
      done_o |-> larger_only_o == (shift_cnt_o > 6'h24))
      else $error("larger flag and count disagree");
   plus_zero_a : assert property (
      done_o |-> !(&{aligned_coef_o, aligned_ext_o}))
      else $error("minus zero delivered");
endmodule : fpfa_checker

bind float_operand_format_align fpfa_checker i_fpfa_checker (.*);

// [verif/float_operand_format_align_tb_top.sv]
`timescale 1ns/10ps
module float_operand_format_align_tb_top;
   typedef struct packed {
      logic        ng;
      logic [9:0]  mg;
      logic [47:0] aq;
      logic [23:0] fw;
      logic [47:0] cb;
      logic [10:0] be;
      logic [11:0] sx;
      logic [23:0] fm;
      logic [23:0] fv;
      logic [1:0]  ge;
      logic [11:0] nt;
   } row_s;
   logic        clk_i, srst_i, fix_sign_o, mul48_i, div48_i, arith_opt_i;
   logic        trap_o, texp_neg_i, fp_sign_o, fp_norm_o, fp_texp_neg_o;
   logic        cmp_gt_o, cmp_eq_o, fp_start_i, fp_sub_i, index_en_i;
   logic        indirect_i, mem_rd_o, mem_ack_i, busy_o, done_o;
   logic        shifted_aq_o, larger_only_o;
   logic [1:0]  lat;
   logic [5:0]  shift_cnt_o;
   logic [9:0]  texp_mag_i, fp_texp_mag_o;
   logic [10:0] bexp_o, fp_bexp_o, eq_exp_o;
   logic [17:0] exec_addr_i, index_i, mem_addr_o;
   logic [22:0] fix_mag_o;
   logic [23:0] fix_word_i, fix_value_o, mem_rdata_i;
   logic [35:0] fp_coef_o;
   logic [36:0] aligned_coef_o, other_coef_o;
   logic [47:0] aq_i, cmp_b_i, opnd_o, aligned_ext_o;
   logic [17:0] rd_q [$];
   int          err_total;
   int          checks_done;
   row_s        rows [4] = '{
      '{1'b0, 10'h3FF, 48'h4038_0000_0000, 24'h00_0005, 48'h0,
        11'h7FF, 12'h403, 24'h00_0005, 24'h00_0005, 2'h2, 12'h803},
      '{1'b1, 10'h000, 48'hBFC7_FFFF_FFFF, 24'hFF_FFFA, 48'h0,
        11'h400, 12'hC03, 24'h80_0005, 24'hFF_FFFA, 2'h0, 12'h803},
      '{1'b1, 10'h003, 48'h3FC8_0000_0000, 24'hFF_FFFF, 48'h4038_0000_0000,
        11'h3FC, 12'h3FC, 24'h80_0000, 24'h00_0000, 2'h0, 12'hC03},
      '{1'b1, 10'h3FF, 48'hFFFF_FFFF_FFFF, 24'h7F_FFFF, 48'h0,
        11'h000, 12'h800, 24'h7F_FFFF, 24'h7F_FFFF, 2'h1, 12'h7FF}};

   float_operand_format_align i_float_operand_format_align (.*);
   fp_store_model i_fp_store_model (.clk_i(clk_i), .srst_i(srst_i),
      .lat_i(lat), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
      .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Addresses taken at the falling edge of each cycle in which the ack is high
   always @(negedge clk_i) begin
      if (mem_rd_o && mem_ack_i) rd_q.push_back(mem_addr_o);
   end

   task automatic print_verdict();
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      checks_done++;
      if (seen !== want) begin
         err_total++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : chk

   task automatic step();
      @(posedge clk_i);
      #1;
   endtask : step

   task automatic run_op(input logic sub, ind, ie, input logic [17:0] ex,
                         idx, input logic [47:0] aq, input logic [1:0] lt);
      int n;
      n = 0;
      step();
      rd_q.delete();
      {fp_sub_i, indirect_i, index_en_i} = {sub, ind, ie};
      {exec_addr_i, index_i, aq_i, lat} = {ex, idx, aq, lt};
      fp_start_i = 1'b1;
      step();
      fp_start_i = 1'b0;
      step();
      // A start while busy has to be dropped
      fp_start_i = 1'b1;
      step();
      fp_start_i = 1'b0;
      while (done_o !== 1'b1 && n < 300) begin
         step();
         n++;
      end
      chk(done_o, 1'b1);
   endtask : run_op

   task automatic chk_op(input logic [47:0] op, input logic [10:0] ee,
      input logic [36:0] ac, input logic [47:0] ax, input logic [36:0] oc,
      input logic [1:0] fl, input logic [5:0] sc);
      chk(opnd_o, op);
      chk(eq_exp_o, ee);
      chk(aligned_coef_o, ac);
      chk(aligned_ext_o, ax);
      chk(other_coef_o, oc);
      chk({shifted_aq_o, larger_only_o}, fl);
      chk(shift_cnt_o, sc);
   endtask : chk_op

   task automatic chk_rd(input int cnt, input logic [17:0] m);
      chk(rd_q.size(), cnt);
      chk(rd_q[cnt-2], m);
      chk(rd_q[cnt-1], m + 18'h0_0001);
   endtask : chk_rd

   initial begin
      repeat (3000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end

   initial begin
      err_total = 0;
      checks_done = 0;
      srst_i = 1'b1;
      {fix_word_i, mul48_i, div48_i, arith_opt_i, texp_neg_i, texp_mag_i} = '0;
      {aq_i, cmp_b_i, fp_start_i, fp_sub_i, exec_addr_i, index_i} = '0;
      {index_en_i, indirect_i, lat} = '0;
      repeat (20) @(posedge clk_i);
      #1;
      srst_i = 1'b0;
      chk({busy_o, done_o, mem_rd_o, trap_o, bexp_o}, 64'h0);
      foreach (rows[k]) begin
         {texp_neg_i, texp_mag_i, aq_i} = {rows[k].ng, rows[k].mg, rows[k].aq};
         {fix_word_i, cmp_b_i} = {rows[k].fw, rows[k].cb};
         step();
         chk(bexp_o, rows[k].be);
         chk({fp_sign_o, fp_bexp_o}, rows[k].sx);
         chk({fp_norm_o, fp_texp_neg_o, fp_texp_mag_o}, rows[k].nt);
         chk({fix_sign_o, fix_mag_o}, rows[k].fm);
         chk(fix_value_o, rows[k].fv);
         chk({cmp_gt_o, cmp_eq_o}, rows[k].ge);
      end
      for (int k = 0; k < 8; k++) begin
         {mul48_i, div48_i, arith_opt_i} = k[2:0];
         step();
         chk(trap_o, (k[2] | k[1]) & ~k[0]);
      end
      i_fp_store_model.mem[8'h15] = 24'h40_3800;
      i_fp_store_model.mem[8'h16] = 24'h00_0000;
      i_fp_store_model.mem[8'h20] = 24'h00_0030;
      i_fp_store_model.mem[8'h30] = 24'h40_0800;
      i_fp_store_model.mem[8'h31] = 24'h00_0000;
      i_fp_store_model.mem[8'h40] = 24'h45_0800;
      i_fp_store_model.mem[8'h41] = 24'h00_0000;
      i_fp_store_model.mem[8'h50] = 24'hFF_FFFF;
      i_fp_store_model.mem[8'h51] = 24'hFF_FFFF;
      // Indexed add, pair has the smaller exponent
      run_op(0, 0, 1, 18'h0_0010, 18'h0_0005, 48'h4008_0000_0000, 2'h0);
      chk_rd(2, 18'h0_0015);
      chk_op(48'h4038_0000_0000, 11'h403, 37'h01_0000_0000, 48'h0,
             37'h08_0000_0000, 2'h2, 6'h03);
      // Indexed indirect subtract, storage shifted as complement
      run_op(1, 1, 1, 18'h0_001E, 18'h0_0002, 48'h4038_0000_0000, 2'h2);
      chk(rd_q[0], 18'h0_0020);
      chk_rd(3, 18'h0_0030);
      chk_op(48'h4008_0000_0000, 11'h403, 37'h1E_FFFF_FFFF,
             48'hFFFF_FFFF_FFFF, 37'h08_0000_0000, 2'h0, 6'h03);
      // Minus zero index, gap past the shift cap
      run_op(0, 0, 1, 18'h0_0040, 18'h3_FFFF, 48'h4008_0000_0000, 2'h1);
      chk_rd(2, 18'h0_0040);
      chk_op(48'h4508_0000_0000, 11'h450, 37'h0, 48'h0000_0010_0000,
             37'h08_0000_0000, 2'h3, 6'h3F);
      // Minus zero storage operand shifts to all ones, delivered as plus zero
      run_op(0, 0, 0, 18'h0_0050, 18'h0_0000, 48'h4008_0000_0000, 2'h0);
      chk_rd(2, 18'h0_0050);
      chk_op(48'hFFFF_FFFF_FFFF, 11'h400, 37'h0, 48'h0,
             37'h08_0000_0000, 2'h1, 6'h3F);
      // Reset in mid fetch returns to idle
      step();
      fp_start_i = 1'b1;
      step();
      fp_start_i = 1'b0;
      step();
      srst_i = 1'b1;
      step();
      step();
      chk({busy_o, mem_rd_o, done_o}, 3'h0);
      srst_i = 1'b0;
      step();
      chk({larger_only_o, shift_cnt_o, opnd_o}, 64'h0);
      print_verdict();
   end
endmodule : float_operand_format_align_tb_top
